// >>> design/dsp_pkg.sv
// Shared constants and types of the dual serial port block
package dsp_pkg;

  localparam int unsigned CLK_HZ     = 100_000_000;
  localparam int unsigned RATE_1200  = 1200;
  localparam int unsigned RATE_2400  = 2400;
  localparam int unsigned RATE_4800  = 4800;
  localparam int unsigned RATE_9600  = 9600;
  localparam int unsigned RATE_19200 = 19200;
  localparam int unsigned RATE_38400 = 38400;
  localparam int unsigned DIAG_RATE  = 9600;

  localparam int DIV_W = 17;

  // Clock cycles per bit, rounded down
  localparam logic [DIV_W-1:0] DIV_1200  = DIV_W'(CLK_HZ / RATE_1200);
  localparam logic [DIV_W-1:0] DIV_2400  = DIV_W'(CLK_HZ / RATE_2400);
  localparam logic [DIV_W-1:0] DIV_4800  = DIV_W'(CLK_HZ / RATE_4800);
  localparam logic [DIV_W-1:0] DIV_9600  = DIV_W'(CLK_HZ / RATE_9600);
  localparam logic [DIV_W-1:0] DIV_19200 = DIV_W'(CLK_HZ / RATE_19200);
  localparam logic [DIV_W-1:0] DIV_38400 = DIV_W'(CLK_HZ / RATE_38400);
  localparam logic [DIV_W-1:0] DIAG_DIV  = DIV_W'(CLK_HZ / DIAG_RATE);

  // Only six rates exist; codes 6 and 7 are refused
  typedef enum logic [2:0] {DSP_B1200, DSP_B2400, DSP_B4800, DSP_B9600, DSP_B19200, DSP_B38400} dsp_baud_t;
  typedef enum logic [1:0] {DSP_PAR_NONE, DSP_PAR_EVEN, DSP_PAR_ODD} dsp_par_t;
  typedef enum logic [1:0] {DSP_P2_SE, DSP_P2_FD, DSP_P2_HD} dsp_p2_mode_t;

  // Reset configuration
  localparam dsp_baud_t    RST_BAUD       = DSP_B9600;
  localparam logic         RST_BITS8      = 1'b1;
  localparam dsp_par_t     RST_PARITY     = DSP_PAR_NONE;
  localparam logic         RST_STOP2      = 1'b0;
  localparam logic         RST_DATA_ON_P2 = 1'b0;
  localparam dsp_p2_mode_t RST_P2_MODE    = DSP_P2_SE;

  // Fixed diagnostics framing
  localparam logic DIAG_BITS8   = 1'b1;
  localparam logic DIAG_PAR_EN  = 1'b1;
  localparam logic DIAG_PAR_ODD = 1'b0;
  localparam logic DIAG_STOP2   = 1'b0;

  // Positions in the synchronised pin vector
  localparam int SYNC_W     = 8;
  localparam int SI_P1_TXD  = 0;
  localparam int SI_PIN2    = 1;
  localparam int SI_PIN3    = 2;
  localparam int SI_PIN4    = 3;
  localparam int SI_PIN5    = 4;
  localparam int SI_RTS     = 5;
  localparam int SI_DTR     = 6;
  localparam int SI_CFG_N   = 7;
  localparam logic [SYNC_W-1:0] SYNC_RST = 8'hFF;

endpackage

// >>> design/dsp_ser_if.sv
// Link between the port router and one character engine
`timescale 1ns/1ns
interface dsp_ser_if;
  logic [dsp_pkg::DIV_W-1:0] div;
  logic                      bits8;
  logic                      par_en;
  logic                      par_odd;
  logic                      stop2;
  logic [7:0]                tx_data;
  logic                      tx_valid;
  logic                      tx_hold;
  logic                      tx_ready;
  logic                      txd;
  logic                      tx_busy;
  logic                      rxd;
  logic [7:0]                rx_data;
  logic                      rx_valid;
  logic                      rx_perr;
  logic                      rx_ferr;
  logic                      rx_busy;

  modport ctl (output div, bits8, par_en, par_odd, stop2, tx_data, tx_valid, tx_hold, rxd,
               input tx_ready, txd, tx_busy, rx_data, rx_valid, rx_perr, rx_ferr, rx_busy);
  modport eng (input div, bits8, par_en, par_odd, stop2, tx_data, tx_valid, tx_hold, rxd,
               output tx_ready, txd, tx_busy, rx_data, rx_valid, rx_perr, rx_ferr, rx_busy);
endinterface

// >>> design/dsp_serial_top.sv
// Dual asynchronous serial port: character engines and port router
`timescale 1ns/1ns
module dsp_char_eng (
  input wire logic clock_i,
  input wire logic rst_n_i,
  dsp_ser_if.eng   s
);
  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} dsp_tx_st_t;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} dsp_rx_st_t;

  dsp_tx_st_t                tx_st_q, tx_st_d;
  logic [dsp_pkg::DIV_W-1:0] tx_cnt_q, tx_cnt_d;
  logic [2:0]                tx_bit_q, tx_bit_d;
  logic [7:0]                tx_sh_q, tx_sh_d;
  logic                      tx_par_q, tx_par_d;
  logic                      tx_stop_q, tx_stop_d;
  logic                      txd_q, txd_d;
  logic                      tx_tick;
  dsp_rx_st_t                rx_st_q, rx_st_d;
  logic [dsp_pkg::DIV_W-1:0] rx_cnt_q, rx_cnt_d;
  logic [2:0]                rx_bit_q, rx_bit_d;
  logic [7:0]                rx_sh_q, rx_sh_d;
  logic                      rx_acc_q, rx_acc_d;
  logic                      rx_pend_q, rx_pend_d;
  logic [7:0]                rx_data_q, rx_data_d;
  logic                      rx_valid_q, rx_valid_d;
  logic                      rx_perr_q, rx_perr_d;
  logic                      rx_ferr_q, rx_ferr_d;
  logic                      rx_tick;
  logic [2:0]                last_bit;

  assign last_bit = s.bits8 ? 3'h7 : 3'h6;

  always_comb begin
    tx_st_d   = tx_st_q;
    tx_cnt_d  = tx_cnt_q;
    tx_bit_d  = tx_bit_q;
    tx_sh_d   = tx_sh_q;
    tx_par_d  = tx_par_q;
    tx_stop_d = tx_stop_q;
    txd_d     = txd_q;
    tx_tick   = (tx_cnt_q == '0);
    if (tx_st_q != TX_IDLE) begin
      tx_cnt_d = tx_tick ? s.div - 1'b1 : tx_cnt_q - 1'b1;
    end
    case (tx_st_q)
      TX_IDLE: begin
        if (s.tx_valid && !s.tx_hold) begin
          tx_sh_d  = s.tx_data;
          tx_par_d = s.par_odd;
          tx_bit_d = 3'h0;
          tx_cnt_d = s.div - 1'b1;
          txd_d    = 1'b0;
          tx_st_d  = TX_START;
        end
      end
      TX_START: begin
        if (tx_tick) begin
          txd_d    = tx_sh_q[0];
          tx_par_d = tx_par_q ^ tx_sh_q[0];
          tx_sh_d  = tx_sh_q >> 1;
          tx_st_d  = TX_DATA;
        end
      end
      TX_DATA: begin
        if (tx_tick) begin
          if (tx_bit_q == last_bit) begin
            if (s.par_en) begin
              txd_d   = tx_par_q;
              tx_st_d = TX_PAR;
            end else begin
              txd_d     = 1'b1;
              tx_stop_d = s.stop2;
              tx_st_d   = TX_STOP;
            end
          end else begin
            tx_bit_d = tx_bit_q + 3'h1;
            txd_d    = tx_sh_q[0];
            tx_par_d = tx_par_q ^ tx_sh_q[0];
            tx_sh_d  = tx_sh_q >> 1;
          end
        end
      end
      TX_PAR: begin
        if (tx_tick) begin
          txd_d     = 1'b1;
          tx_stop_d = s.stop2;
          tx_st_d   = TX_STOP;
        end
      end
      TX_STOP: begin
        if (tx_tick) begin
          if (tx_stop_q) begin
            tx_stop_d = 1'b0;
          end else begin
            tx_cnt_d = '0;
            tx_st_d  = TX_IDLE;
          end
        end
      end
      default: tx_st_d = TX_IDLE;
    endcase
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tx_st_q   <= TX_IDLE;
      tx_cnt_q  <= '0;
      tx_bit_q  <= 3'h0;
      tx_sh_q   <= 8'h00;
      tx_par_q  <= 1'b0;
      tx_stop_q <= 1'b0;
      txd_q     <= 1'b1;
    end else begin
      tx_st_q   <= tx_st_d;
      tx_cnt_q  <= tx_cnt_d;
      tx_bit_q  <= tx_bit_d;
      tx_sh_q   <= tx_sh_d;
      tx_par_q  <= tx_par_d;
      tx_stop_q <= tx_stop_d;
      txd_q     <= txd_d;
    end
  end

  // Receiver samples mid-bit; only the first stop bit is checked
  always_comb begin
    rx_st_d    = rx_st_q;
    rx_cnt_d   = rx_cnt_q;
    rx_bit_d   = rx_bit_q;
    rx_sh_d    = rx_sh_q;
    rx_acc_d   = rx_acc_q;
    rx_pend_d  = rx_pend_q;
    rx_data_d  = rx_data_q;
    rx_perr_d  = rx_perr_q;
    rx_ferr_d  = rx_ferr_q;
    rx_valid_d = 1'b0;
    rx_tick    = (rx_cnt_q == '0);
    if (rx_st_q != RX_IDLE) begin
      rx_cnt_d = rx_tick ? s.div - 1'b1 : rx_cnt_q - 1'b1;
    end
    case (rx_st_q)
      RX_IDLE: begin
        if (!s.rxd) begin
          rx_cnt_d  = s.div >> 1;
          rx_bit_d  = 3'h0;
          rx_sh_d   = 8'h00;
          rx_acc_d  = s.par_odd;
          rx_pend_d = 1'b0;
          rx_st_d   = RX_START;
        end
      end
      RX_START: begin
        if (rx_tick) begin
          rx_st_d = s.rxd ? RX_IDLE : RX_DATA;
        end
      end
      RX_DATA: begin
        if (rx_tick) begin
          rx_sh_d[rx_bit_q] = s.rxd;
          rx_acc_d          = rx_acc_q ^ s.rxd;
          rx_bit_d          = rx_bit_q + 3'h1;
          if (rx_bit_q == last_bit) begin
            rx_st_d = s.par_en ? RX_PAR : RX_STOP;
          end
        end
      end
      RX_PAR: begin
        if (rx_tick) begin
          rx_pend_d = s.rxd ^ rx_acc_q;
          rx_st_d   = RX_STOP;
        end
      end
      RX_STOP: begin
        if (rx_tick) begin
          rx_data_d  = rx_sh_q;
          rx_perr_d  = rx_pend_q;
          rx_ferr_d  = !s.rxd;
          rx_valid_d = 1'b1;
          rx_cnt_d   = '0;
          rx_st_d    = RX_IDLE;
        end
      end
      default: rx_st_d = RX_IDLE;
    endcase
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_st_q    <= RX_IDLE;
      rx_cnt_q   <= '0;
      rx_bit_q   <= 3'h0;
      rx_sh_q    <= 8'h00;
      rx_acc_q   <= 1'b0;
      rx_pend_q  <= 1'b0;
      rx_data_q  <= 8'h00;
      rx_valid_q <= 1'b0;
      rx_perr_q  <= 1'b0;
      rx_ferr_q  <= 1'b0;
    end else begin
      rx_st_q    <= rx_st_d;
      rx_cnt_q   <= rx_cnt_d;
      rx_bit_q   <= rx_bit_d;
      rx_sh_q    <= rx_sh_d;
      rx_acc_q   <= rx_acc_d;
      rx_pend_q  <= rx_pend_d;
      rx_data_q  <= rx_data_d;
      rx_valid_q <= rx_valid_d;
      rx_perr_q  <= rx_perr_d;
      rx_ferr_q  <= rx_ferr_d;
    end
  end

  assign s.tx_ready = (tx_st_q == TX_IDLE) && !s.tx_hold;
  assign s.txd      = txd_q;
  assign s.tx_busy  = (tx_st_q != TX_IDLE);
  assign s.rx_data  = rx_data_q;
  assign s.rx_valid = rx_valid_q;
  assign s.rx_perr  = rx_perr_q;
  assign s.rx_ferr  = rx_ferr_q;
  assign s.rx_busy  = (rx_st_q != RX_IDLE);
endmodule

module dsp_serial_top (
  input  wire logic       clock_i,
  input  wire logic       rst_n_i,
  input  wire logic       cfg_select_n_i,
  input  wire logic       local_display_i,
  input  wire logic       cfg_load_i,
  input  wire logic       cfg_data_on_p2_i,
  input  wire logic [1:0] cfg_p2_mode_i,
  input  wire logic [2:0] cfg_baud_i,
  input  wire logic       cfg_bits8_i,
  input  wire logic [1:0] cfg_parity_i,
  input  wire logic       cfg_stop2_i,
  input  wire logic       rts_flow_en_i,
  output logic            prog_mode_o,
  output logic            data_on_p2_o,
  input  wire logic       p1_txd_i,
  output logic            p1_rxd_o,
  input  wire logic       p2_pin2_i,
  output logic            p2_pin2_o,
  output logic            p2_pin2_oe_o,
  input  wire logic       p2_pin3_i,
  output logic            p2_pin3_o,
  output logic            p2_pin3_oe_o,
  input  wire logic       p2_pin4_i,
  input  wire logic       p2_pin5_i,
  input  wire logic       rts_i,
  input  wire logic       dtr_i,
  output logic            cts_o,
  output logic            dsr_o,
  output logic            dte_ready_o,
  input  wire logic       carrier_i,
  input  wire logic       tx_buf_risk_i,
  input  wire logic [7:0] data_out_data_i,
  input  wire logic       data_out_valid_i,
  output logic            data_out_ready_o,
  output logic [7:0]      data_in_data_o,
  output logic            data_in_valid_o,
  output logic            data_in_perr_o,
  output logic            data_in_ferr_o,
  input  wire logic [7:0] diag_out_data_i,
  input  wire logic       diag_out_valid_i,
  output logic            diag_out_ready_o,
  output logic [7:0]      diag_in_data_o,
  output logic            diag_in_valid_o,
  output logic            diag_in_perr_o,
  output logic            diag_in_ferr_o
);
  logic [dsp_pkg::SYNC_W-1:0] pin_s;
  dsp_pkg::dsp_baud_t         baud_q, baud_d;
  logic                       bits8_q, bits8_d;
  dsp_pkg::dsp_par_t          par_q, par_d;
  logic                       stop2_q, stop2_d;
  logic                       on_p2_q, on_p2_d;
  dsp_pkg::dsp_p2_mode_t      p2_mode_q, p2_mode_d;
  logic                       cfg_ok;
  logic                       prog;
  logic                       data_p2;
  logic                       hd;
  logic                       p2_line;
  logic                       p2_txd;
  logic                       p2_busy;
  logic                       p1_rxd_d, p1_rxd_q;
  logic                       pin2_d, pin2_q, pin2_oe_d, pin2_oe_q;
  logic                       pin3_d, pin3_q, pin3_oe_d, pin3_oe_q;
  logic                       cts_d, cts_q;
  logic                       dsr_q;
  logic                       prog_q;

  dsp_ser_if d_if ();
  dsp_ser_if g_if ();

  // Receiver sees one unless A is below B
  function automatic logic diff_bit(input logic a, input logic b);
    diff_bit = a | ~b;
  endfunction

  function automatic logic [dsp_pkg::DIV_W-1:0] baud_div(input dsp_pkg::dsp_baud_t b);
    case (b)
      dsp_pkg::DSP_B1200:  baud_div = dsp_pkg::DIV_1200;
      dsp_pkg::DSP_B2400:  baud_div = dsp_pkg::DIV_2400;
      dsp_pkg::DSP_B4800:  baud_div = dsp_pkg::DIV_4800;
      dsp_pkg::DSP_B19200: baud_div = dsp_pkg::DIV_19200;
      dsp_pkg::DSP_B38400: baud_div = dsp_pkg::DIV_38400;
      default:             baud_div = dsp_pkg::DIV_9600;
    endcase
  endfunction

  dsp_sync #(
    .W       (dsp_pkg::SYNC_W),
    .RST_VAL (dsp_pkg::SYNC_RST)
  ) u_sync (
    .clock_i (clock_i),
    .rst_n_i (rst_n_i),
    .async_i ({cfg_select_n_i, dtr_i, rts_i, p2_pin5_i, p2_pin4_i, p2_pin3_i, p2_pin2_i, p1_txd_i}),
    .sync_o  (pin_s)
  );

  assign prog   = !pin_s[dsp_pkg::SI_CFG_N];
  assign cfg_ok = cfg_load_i && (prog || local_display_i);

  // Bad codes leave the stored setting untouched
  always_comb begin
    baud_d    = baud_q;
    bits8_d   = bits8_q;
    par_d     = par_q;
    stop2_d   = stop2_q;
    on_p2_d   = on_p2_q;
    p2_mode_d = p2_mode_q;
    if (cfg_ok) begin
      if (cfg_baud_i <= 3'(dsp_pkg::DSP_B38400)) begin
        baud_d = dsp_pkg::dsp_baud_t'(cfg_baud_i);
      end
      if (cfg_parity_i != 2'h3) begin
        par_d = dsp_pkg::dsp_par_t'(cfg_parity_i);
      end
      if (cfg_p2_mode_i != 2'h3) begin
        p2_mode_d = dsp_pkg::dsp_p2_mode_t'(cfg_p2_mode_i);
      end
      bits8_d = cfg_bits8_i;
      stop2_d = cfg_stop2_i;
      on_p2_d = cfg_data_on_p2_i;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      baud_q    <= dsp_pkg::RST_BAUD;
      bits8_q   <= dsp_pkg::RST_BITS8;
      par_q     <= dsp_pkg::RST_PARITY;
      stop2_q   <= dsp_pkg::RST_STOP2;
      on_p2_q   <= dsp_pkg::RST_DATA_ON_P2;
      p2_mode_q <= dsp_pkg::RST_P2_MODE;
    end else begin
      baud_q    <= baud_d;
      bits8_q   <= bits8_d;
      par_q     <= par_d;
      stop2_q   <= stop2_d;
      on_p2_q   <= on_p2_d;
      p2_mode_q <= p2_mode_d;
    end
  end

  assign data_p2 = on_p2_q && !prog;
  assign hd      = (p2_mode_q == dsp_pkg::DSP_P2_HD);
  assign p2_txd  = data_p2 ? d_if.txd : g_if.txd;
  assign p2_busy = data_p2 ? d_if.tx_busy : g_if.tx_busy;

  // Port 2 receive line per mode; own echo is masked on the shared pair
  always_comb begin
    case (p2_mode_q)
      dsp_pkg::DSP_P2_FD: p2_line = diff_bit(pin_s[dsp_pkg::SI_PIN4], pin_s[dsp_pkg::SI_PIN5]);
      dsp_pkg::DSP_P2_HD: p2_line = diff_bit(pin_s[dsp_pkg::SI_PIN2], pin_s[dsp_pkg::SI_PIN3]);
      default:            p2_line = pin_s[dsp_pkg::SI_PIN4];
    endcase
    if (hd && p2_busy) begin
      p2_line = 1'b1;
    end
  end

  assign d_if.div      = baud_div(baud_q);
  assign d_if.bits8    = bits8_q;
  assign d_if.par_en   = (par_q != dsp_pkg::DSP_PAR_NONE);
  assign d_if.par_odd  = (par_q == dsp_pkg::DSP_PAR_ODD);
  assign d_if.stop2    = stop2_q;
  assign d_if.tx_data  = data_out_data_i;
  assign d_if.tx_valid = data_out_valid_i;
  assign d_if.tx_hold  = (rts_flow_en_i && !pin_s[dsp_pkg::SI_RTS]) || (data_p2 && hd && d_if.rx_busy);
  assign d_if.rxd      = data_p2 ? p2_line : pin_s[dsp_pkg::SI_P1_TXD];

  assign g_if.div      = dsp_pkg::DIAG_DIV;
  assign g_if.bits8    = dsp_pkg::DIAG_BITS8;
  assign g_if.par_en   = dsp_pkg::DIAG_PAR_EN;
  assign g_if.par_odd  = dsp_pkg::DIAG_PAR_ODD;
  assign g_if.stop2    = dsp_pkg::DIAG_STOP2;
  assign g_if.tx_data  = diag_out_data_i;
  assign g_if.tx_valid = diag_out_valid_i;
  assign g_if.tx_hold  = !data_p2 && hd && g_if.rx_busy;
  assign g_if.rxd      = data_p2 ? pin_s[dsp_pkg::SI_P1_TXD] : p2_line;

  dsp_char_eng u_data (
    .clock_i (clock_i),
    .rst_n_i (rst_n_i),
    .s       (d_if.eng)
  );

  dsp_char_eng u_diag (
    .clock_i (clock_i),
    .rst_n_i (rst_n_i),
    .s       (g_if.eng)
  );

  // Pin drive per port 2 mode
  always_comb begin
    p1_rxd_d  = data_p2 ? g_if.txd : d_if.txd;
    pin2_d    = p2_txd;
    pin3_d    = !p2_txd;
    pin2_oe_d = 1'b1;
    pin3_oe_d = 1'b1;
    case (p2_mode_q)
      dsp_pkg::DSP_P2_SE: begin
        pin2_d = carrier_i;
        pin3_d = p2_txd;
      end
      dsp_pkg::DSP_P2_HD: begin
        pin2_oe_d = p2_busy;
        pin3_oe_d = p2_busy;
      end
      default: begin
        pin2_oe_d = 1'b1;
      end
    endcase
    cts_d = !tx_buf_risk_i;
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      p1_rxd_q  <= 1'b1;
      pin2_q    <= 1'b1;
      pin2_oe_q <= 1'b0;
      pin3_q    <= 1'b1;
      pin3_oe_q <= 1'b0;
      cts_q     <= 1'b0;
      dsr_q     <= 1'b0;
      prog_q    <= 1'b0;
    end else begin
      p1_rxd_q  <= p1_rxd_d;
      pin2_q    <= pin2_d;
      pin2_oe_q <= pin2_oe_d;
      pin3_q    <= pin3_d;
      pin3_oe_q <= pin3_oe_d;
      cts_q     <= cts_d;
      dsr_q     <= 1'b1;
      prog_q    <= prog;
    end
  end

  assign p1_rxd_o         = p1_rxd_q;
  assign p2_pin2_o        = pin2_q;
  assign p2_pin2_oe_o     = pin2_oe_q;
  assign p2_pin3_o        = pin3_q;
  assign p2_pin3_oe_o     = pin3_oe_q;
  assign cts_o            = cts_q;
  assign dsr_o            = dsr_q;
  assign dte_ready_o      = pin_s[dsp_pkg::SI_DTR];
  assign prog_mode_o      = prog_q;
  assign data_on_p2_o     = on_p2_q;
  assign data_out_ready_o = d_if.tx_ready;
  assign data_in_data_o   = d_if.rx_data;
  assign data_in_valid_o  = d_if.rx_valid;
  assign data_in_perr_o   = d_if.rx_perr;
  assign data_in_ferr_o   = d_if.rx_ferr;
  assign diag_out_ready_o = g_if.tx_ready;
  assign diag_in_data_o   = g_if.rx_data;
  assign diag_in_valid_o  = g_if.rx_valid;
  assign diag_in_perr_o   = g_if.rx_perr;
  assign diag_in_ferr_o   = g_if.rx_ferr;
endmodule

// >>> design/dsp_sync.sv
// Two-stage synchroniser for a vector of pin inputs
`timescale 1ns/1ns
module dsp_sync #(
  parameter int                W       = 8,
  parameter logic [W-1:0]      RST_VAL = '1
) (
  input  wire logic         clock_i,
  input  wire logic         rst_n_i,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        meta_q[i] <= RST_VAL[i];
        sync_q[i] <= RST_VAL[i];
      end else begin
        meta_q[i] <= async_i[i];
        sync_q[i] <= meta_q[i];
      end
    end
  end

  assign sync_o = sync_q;
endmodule

// >>> tb/dsp_dte_model.sv
// Terminal-side serial port model on port one
`timescale 1ns/1ns
module dsp_dte_model (
  input  wire logic clock_i,
  input  wire logic rxd_i,
  output logic      txd_o
);
  int div = int'(dsp_pkg::DIV_38400);
  bit b8 = 1'b1, pe, po, s2;
  // Line rests at mark level between characters
  initial txd_o = 1'b1;
  task automatic put(input logic b);
    txd_o = b;
    repeat (div) @(negedge clock_i);
  endtask
  task automatic send(input logic [7:0] d);
    put(1'b0);
    for (int i = 0; i < 7 + b8; i++) put(d[i]);
    if (pe) put(^{b8 & d[7], d[6:0]} ^ po);
    put(1'b1);
    if (s2) put(1'b1);
  endtask
  task automatic recv(output logic [7:0] d, output logic p, output logic s);
    {d, p} = '0;
    @(negedge rxd_i);
    repeat (div / 2) @(negedge clock_i);
    for (int i = 0; i < 7 + b8; i++) begin
      repeat (div) @(negedge clock_i);
      d[i] = rxd_i;
    end
    repeat (div) @(negedge clock_i);
    if (pe) p = rxd_i;
    if (pe) repeat (div) @(negedge clock_i);
    s = rxd_i;
  endtask
endmodule

// >>> tb/dsp_serial_asserts.sv
// Pin-level checks for the dual serial port top
`timescale 1ns/1ns
module dsp_serial_asserts (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic cfg_select_n_i,
  input wire logic local_display_i,
  input wire logic cfg_load_i,
  input wire logic tx_buf_risk_i,
  input wire logic cts_o,
  input wire logic dsr_o,
  input wire logic dtr_i,
  input wire logic dte_ready_o,
  input wire logic prog_mode_o,
  input wire logic data_on_p2_o,
  input wire logic p1_rxd_o,
  input wire logic data_out_valid_i,
  input wire logic data_out_ready_o,
  input wire logic diag_out_valid_i,
  input wire logic diag_out_ready_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_data_go; data_out_valid_i && data_out_ready_o; endsequence
  sequence s_diag_go; diag_out_valid_i && diag_out_ready_o; endsequence
  sequence s_p1_start; ##[1:3] !p1_rxd_o [*8]; endsequence
  a_cts_risk_drop: assert property ($rose(tx_buf_risk_i) |=> !cts_o)
    else $error("cts high after buffer risk");
  a_data_busy_hold: assert property (s_data_go |=> !data_out_ready_o [*8])
    else $error("ready back within a character");
  a_data_on_p1: assert property (s_data_go ##0 (!data_on_p2_o || prog_mode_o) |-> s_p1_start)
    else $error("data start bit missing on port one");
  a_diag_on_p1: assert property (s_diag_go ##0 (data_on_p2_o && !prog_mode_o) |-> s_p1_start)
    else $error("diag start bit missing on port one");
  a_dsr_after_reset: assert property ($rose(rst_n_i) |=> dsr_o)
    else $error("dsr low after reset");
  a_dtr_follow: assert property ($stable(dtr_i) [*3] |-> dte_ready_o == dtr_i)
    else $error("terminal ready not following dtr");
  a_prog_enter: assert property (!cfg_select_n_i [*5] |-> prog_mode_o)
    else $error("programming mode not entered");
  a_load_refused: assert property (cfg_load_i && !local_display_i && cfg_select_n_i &&
    $past(cfg_select_n_i) && $past(cfg_select_n_i, 2) && $past(cfg_select_n_i, 3) |=> $stable(data_on_p2_o))
    else $error("config load taken outside programming");
endmodule

// >>> tb/dsp_serial_top_tb.sv
// Self-checking bench for the dual serial port top level
`timescale 1ns/1ns
module dsp_serial_top_tb;
  logic clock_i = '0, rst_n_i = '0, cfg_select_n_i = '1, local_display_i = '1, cfg_load_i = '0;
  logic cfg_data_on_p2_i = '0, cfg_bits8_i = '1, cfg_stop2_i = '0, rts_flow_en_i = '0, p2_pin2_i = '1;
  logic [1:0] cfg_p2_mode_i = '0, cfg_parity_i = '0;
  logic [2:0] cfg_baud_i = '0;
  logic p2_pin3_i = '1, p2_pin4_i = '1, p2_pin5_i = '0, rts_i = '1, dtr_i = '1, carrier_i = '0;
  logic tx_buf_risk_i = '0, data_out_valid_i = '0, diag_out_valid_i = '0;
  logic [7:0] data_out_data_i = '0, diag_out_data_i = '0, data_in_data_o, diag_in_data_o, tx_b, rx_b, got;
  logic prog_mode_o, data_on_p2_o, p1_rxd_o, p2_pin2_o, p2_pin2_oe_o, p2_pin3_o, p2_pin3_oe_o, cts_o, dsr_o;
  logic dte_ready_o, data_out_ready_o, data_in_valid_o, data_in_perr_o, data_in_ferr_o, par_b, stop_b;
  logic diag_out_ready_o, diag_in_valid_o, diag_in_perr_o, diag_in_ferr_o;
  wire p1_txd_i;
  int failures = 0, samples_checked = 0, cycles = 0, seed = 32'h21cee38d;
  dsp_serial_top dut (.clock_i, .rst_n_i, .cfg_select_n_i, .local_display_i, .cfg_load_i, .cfg_data_on_p2_i,
    .cfg_p2_mode_i, .cfg_baud_i, .cfg_bits8_i, .cfg_parity_i, .cfg_stop2_i, .rts_flow_en_i, .prog_mode_o,
    .data_on_p2_o, .p1_txd_i, .p1_rxd_o, .p2_pin2_i, .p2_pin2_o, .p2_pin2_oe_o, .p2_pin3_i, .p2_pin3_o,
    .p2_pin3_oe_o, .p2_pin4_i, .p2_pin5_i, .rts_i, .dtr_i, .cts_o, .dsr_o, .dte_ready_o, .carrier_i,
    .tx_buf_risk_i, .data_out_data_i, .data_out_valid_i, .data_out_ready_o, .data_in_data_o, .data_in_valid_o,
    .data_in_perr_o, .data_in_ferr_o, .diag_out_data_i, .diag_out_valid_i, .diag_out_ready_o, .diag_in_data_o,
    .diag_in_valid_o, .diag_in_perr_o, .diag_in_ferr_o);
  dsp_dte_model dte (.clock_i, .rxd_i(p1_rxd_o), .txd_o(p1_txd_i));
  always #5 clock_i = ~clock_i;
  // Three characters at the fastest rate take about 85000 cycles
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 95000) begin
      failures++;
      test_done();
    end
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic wt(input int n);
    repeat (n) @(negedge clock_i);
  endtask
  task automatic load(input logic p2, input logic [2:0] bd, input logic b8, input logic [1:0] par, input logic s2);
    @(negedge clock_i);
    {cfg_data_on_p2_i, cfg_baud_i, cfg_bits8_i, cfg_parity_i, cfg_stop2_i, cfg_load_i} = {p2, bd, b8, par, s2, 1'b1};
    wt(1);
    cfg_load_i = '0;
  endtask
  task automatic offer(input logic dg);
    @(negedge clock_i);
    {diag_out_valid_i, data_out_valid_i} = {dg, !dg};
    wt(1);
    {diag_out_valid_i, data_out_valid_i} = '0;
    wt(3);
  endtask
  function automatic logic par_of(input logic [7:0] d, input logic b8, input logic odd);
    return ^{b8 & d[7], d[6:0]} ^ odd;
  endfunction
  // Full-duplex exchange on port one; bad flips the terminal's parity sense
  task automatic xfer(input logic b8, input logic pe, input logic po, input logic s2, input logic bad);
    {tx_b, rx_b} = 16'($random(seed));
    {dte.b8, dte.pe, dte.po, dte.s2} = {b8, pe, po ^ bad, s2};
    @(negedge clock_i);
    {data_out_data_i, data_out_valid_i} = {tx_b, 1'b1};
    fork
      dte.send(rx_b);
      begin
        dte.recv(got, par_b, stop_b);
        wt(dte.div);
        check({data_out_ready_o, p1_rxd_o}, {!s2, 1'b1});
      end
      begin
        wt(1);
        data_out_valid_i = '0;
        do wt(1); while (data_in_valid_o !== 1'b1);
        check({data_in_perr_o, data_in_ferr_o, data_in_data_o}, {pe & bad, 1'b0, b8 & rx_b[7], rx_b[6:0]});
      end
    join
    check({got, par_b, stop_b}, {b8 & tx_b[7], tx_b[6:0], pe & par_of(tx_b, b8, po), 1'b1});
  endtask
  initial begin
    wt(6);
    rst_n_i = '1;
    wt(3);
    check({cts_o, dsr_o, data_on_p2_o, p1_rxd_o}, 4'hD);
    load(0, 3'h5, 1, 2'h2, 1);
    xfer(1, 1, 1, 1, 0);
    $display("test 1 done");
    load(0, 3'h5, 0, 2'h1, 0);
    load(0, 3'h7, 0, 2'h3, 0);
    xfer(0, 1, 0, 0, 1);
    $display("test 2 done");
    for (int i = 0; i < 4; i++) begin
      {rts_flow_en_i, tx_buf_risk_i, carrier_i, dtr_i, rts_i, p2_pin5_i} = 6'($random(seed));
      wt(4);
      check({cts_o, p2_pin2_o, dte_ready_o, data_out_ready_o},
            {!tx_buf_risk_i, carrier_i, dtr_i, !rts_flow_en_i | rts_i});
    end
    {rts_flow_en_i, dtr_i, local_display_i} = 3'h2;
    load(1, 3'h5, 1, 2'h0, 0);
    wt(2);
    check(data_on_p2_o, 1'b0);
    cfg_select_n_i = '0;
    wt(5);
    load(1, 3'h5, 1, 2'h0, 0);
    offer(0);
    check({prog_mode_o, data_on_p2_o, p1_rxd_o}, 3'h6);
    cfg_select_n_i = '1;
    wt(5);
    rst_n_i = '0;
    wt(3);
    rst_n_i = '1;
    wt(3);
    check({prog_mode_o, data_on_p2_o, p1_rxd_o}, 3'h1);
    local_display_i = '1;
    load(1, 3'h5, 1, 2'h0, 0);
    offer(1);
    check({data_on_p2_o, p1_rxd_o}, 2'h2);
    offer(0);
    check(p2_pin3_o, 1'b0);
    // Switch the busy port to the shared pair while the start bit is out
    cfg_p2_mode_i = 2'h2;
    load(1, 3'h5, 1, 2'h0, 0);
    wt(2);
    check({p2_pin2_o, p2_pin3_o, p2_pin2_oe_o, p2_pin3_oe_o}, 4'h7);
    do wt(1); while (p2_pin2_oe_o !== 1'b0);
    check({p2_pin3_oe_o, p2_pin2_o, p2_pin3_o, data_out_ready_o}, 4'h5);
    $display("test 3 done");
    test_done();
  end
endmodule
bind dsp_serial_top dsp_serial_asserts u_chk (.clock_i, .rst_n_i, .cfg_select_n_i, .local_display_i, .cfg_load_i,
  .tx_buf_risk_i, .cts_o, .dsr_o, .dtr_i, .dte_ready_o, .prog_mode_o, .data_on_p2_o, .p1_rxd_o,
  .data_out_valid_i, .data_out_ready_o, .diag_out_valid_i, .diag_out_ready_o);
